// ### design/port_pkg.sv
package port_pkg;

    localparam int NUM_PORTS = 7;
    localparam int PORT_W = 8;
    localparam int NUM_PINS = 56;
    localparam int NUM_MODEM = 7;
    localparam int SYNC_W = 63;

    // pin positions, port p bit b sits at p*8+b
    localparam int DBG_PIN = 48;
    localparam int OSC_OUT_PIN = 49;
    localparam int EXT_CLK_PIN = 50;
    localparam int STAT_ONE_PIN = 39;
    localparam int STAT_TWO_PIN = 38;
    localparam int KBI_UPPER_LO = 4;

    // pins that have a peripheral alternate function
    localparam logic [55:0] ALT_CAPABLE = 56'h07_003F_FF0F_FFFF;

    // register map, byte addresses
    localparam int ADDR_W = 8;
    localparam logic [1:0] SEL_DATA = 2'h0;
    localparam logic [1:0] SEL_DIR = 2'h1;
    localparam logic [1:0] SEL_PULL = 2'h2;
    localparam logic [7:0] CFG_ADDR = 8'h70;
    localparam logic [7:0] STATUS_ADDR = 8'h74;
    localparam logic [7:0] MODEM_DATA_ADDR = 8'h78;
    localparam logic [7:0] MODEM_DIR_ADDR = 8'h7C;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // reset values
    localparam logic [7:0] PORT_RST = 8'h00;
    localparam logic [6:0] MODEM_RST = 7'h00;
    localparam logic [62:0] SYNC_RST = 63'h0001_0000_0000_0000;

    // debug link timing: bit time in debug clock cycles, debug clock = bus clock
    localparam int BDC_CYCLES_PER_BIT = 16;
    localparam int BDC_CLK_DIV = 1;
    localparam logic [4:0] BIT_CYCLES = 5'(BDC_CYCLES_PER_BIT * BDC_CLK_DIV);
    localparam logic [2:0] STRAP_SETTLE_CYCLES = 3'h5;

    typedef struct packed {
        logic [3:0] kbi_rise;
        logic [3:0] kbi_en;
        logic irq_pull_en;
        logic irq_rising;
        logic irq_en;
        logic dbg_gpio;
        logic modem_clock_output_ext;
        logic oscillator_output_pin;
    } cfg_t;

    localparam cfg_t CFG_RST = cfg_t'(14'h0000);

    typedef struct packed {
        logic out;
        logic oe;
        logic pull_up;
        logic pull_dn;
    } pad_t;

    localparam pad_t PAD_RST = pad_t'(4'h0);

endpackage

// ### design/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] stable_q
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    // three stages; a change counts once stage two and three agree
    genvar i;
    for (i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
                s1_q[i] <= RST_VAL[i];
                s2_q[i] <= RST_VAL[i];
                s3_q[i] <= RST_VAL[i];
                stable_q[i] <= RST_VAL[i];
            end else if (ce) begin
                s1_q[i] <= async_in[i];
                s2_q[i] <= s1_q[i];
                s3_q[i] <= s2_q[i];
                if (s2_q[i] == s3_q[i]) begin
                    stable_q[i] <= s3_q[i];
                end
            end
        end
    end
endmodule // pin_sync

// ### design/pad_logic.sv
`timescale 1ns/1ps
module pad_logic (
    input wire logic dir,
    input wire logic data,
    input wire logic pull_en,
    input wire logic owned,
    input wire logic p_oe,
    input wire logic p_out,
    input wire logic pull_down,
    input wire logic blocked,
    input wire logic out_only,
    output port_pkg::pad_t pad
);
    import port_pkg::*;

    logic oe;
    logic as_input;

    // peripheral steers the buffer when it owns the pin
    assign oe = blocked ? 1'b0 : (owned ? p_oe : (out_only | dir));
    // a pull only on a real input, never on a direction-bit output
    assign as_input = !oe && !blocked && !(dir && !owned);
    assign pad.out = owned ? p_out : data;
    assign pad.oe = oe;
    assign pad.pull_up = pull_en && as_input && !pull_down;
    assign pad.pull_dn = pull_en && as_input && pull_down;
endmodule // pad_logic

// ### design/port_pin_ctrl.sv
// The implementer's own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
module port_pin_ctrl (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic CE,
    // AXI4-Lite slave
    input wire logic [port_pkg::ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [port_pkg::ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // port pads
    input wire logic [port_pkg::NUM_PINS-1:0] PIN_IN,
    output port_pkg::pad_t [port_pkg::NUM_PINS-1:0] PAD,
    // peripherals
    input wire logic [port_pkg::NUM_PINS-1:0] PERIPH_OWN,
    input wire logic [port_pkg::NUM_PINS-1:0] PERIPH_OE,
    input wire logic [port_pkg::NUM_PINS-1:0] PERIPH_OUT,
    output logic [port_pkg::NUM_PINS-1:0] PERIPH_IN,
    // modem lines
    input wire logic [port_pkg::NUM_MODEM-1:0] MODEM_PIN_IN,
    output logic [port_pkg::NUM_MODEM-1:0] MODEM_PAD_OUT,
    output logic [port_pkg::NUM_MODEM-1:0] MODEM_PAD_OE,
    // external interrupt pin pulls
    output logic IRQ_PULL_UP,
    output logic IRQ_PULL_DN,
    // debug
    output logic ACTIVE_BKGD_MODE,
    output logic BDC_BIT_START,
    output logic BDC_BIT_END
);
    import port_pkg::*;

    // ---------------- register state ----------------
    logic [PORT_W-1:0] data_q [NUM_PORTS];
    logic [PORT_W-1:0] dir_q [NUM_PORTS];
    logic [PORT_W-1:0] pull_q [NUM_PORTS];
    cfg_t cfg_q;
    logic [NUM_MODEM-1:0] mdata_q;
    logic [NUM_MODEM-1:0] mdir_q;

    // ---------------- bus slave state ----------------
    logic awready_q;
    logic wready_q;
    logic aw_have_q;
    logic w_have_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [13:0] wdata_q;
    logic wstrb0_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic arready_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    // ---------------- debug state ----------------
    logic [2:0] strap_cnt_q;
    logic bkgd_q;
    logic bit_busy_q;
    logic [4:0] bit_cnt_q;
    logic dbg_prev_q;
    logic bit_start_q;
    logic bit_end_q;

    // ---------------- synchronised inputs ----------------
    logic [SYNC_W-1:0] sync_q;
    logic [NUM_PINS-1:0] pin_s;
    logic [NUM_MODEM-1:0] modem_s;

    // all outside levels pass one three-stage filter
    pin_sync #(.W(SYNC_W), .RST_VAL(SYNC_RST)) u_sync (
        .clk(CLK),
        .reset_n(RESET_N),
        .ce(CE),
        .async_in({MODEM_PIN_IN, PIN_IN}),
        .stable_q(sync_q)
    );
    assign pin_s = sync_q[NUM_PINS-1:0];
    assign modem_s = sync_q[SYNC_W-1:NUM_PINS];

    // ---------------- modem status lines into port E ----------------
    logic line_one;
    logic line_two;
    assign line_one = mdir_q[0] ? mdata_q[0] : modem_s[0];
    assign line_two = mdir_q[1] ? mdata_q[1] : modem_s[1];

    // pin level seen by the port: E7/E6 carry the modem status lines
    logic [NUM_PINS-1:0] pin_lvl;
    always_comb begin
        pin_lvl = pin_s;
        pin_lvl[STAT_ONE_PIN] = line_one;
        pin_lvl[STAT_TWO_PIN] = line_two;
    end

    // ---------------- flattened control vectors ----------------
    logic [NUM_PINS-1:0] dir_v;
    logic [NUM_PINS-1:0] data_v;
    logic [NUM_PINS-1:0] pull_v;
    logic [NUM_PINS-1:0] owned_v;
    logic [NUM_PINS-1:0] blocked_v;
    logic [NUM_PINS-1:0] pulldn_v;
    logic [NUM_PINS-1:0] outonly_v;
    logic [NUM_PINS-1:0] read_v;
    pad_t [NUM_PINS-1:0] pad_d;

    genvar p;
    genvar b;
    for (p = 0; p < NUM_PORTS; p++) begin : g_port
        for (b = 0; b < PORT_W; b++) begin : g_bit
            localparam int N = p * PORT_W + b;
            logic is_dbg;
            logic is_kbi_up;
            assign is_dbg = (N == DBG_PIN);
            assign is_kbi_up = (p == 0) && (b >= KBI_UPPER_LO);
            assign dir_v[N] = dir_q[p][b];
            assign data_v[N] = data_q[p][b];
            // debug role keeps its internal pull-up on
            assign pull_v[N] = is_dbg ? (!cfg_q.dbg_gpio || pull_q[p][b]) : pull_q[p][b];
            // debug controller owns the pin unless it is a port bit
            assign owned_v[N] = is_dbg ? !cfg_q.dbg_gpio
                                       : (PERIPH_OWN[N] && ALT_CAPABLE[N]);
            // both oscillator pins lost to a crystal, the clock input pin also to the modem clock; E7/E6 lost when their modem line is an output
            assign blocked_v[N] = ((N == OSC_OUT_PIN) && cfg_q.oscillator_output_pin)
                               || ((N == EXT_CLK_PIN) && (cfg_q.oscillator_output_pin || cfg_q.modem_clock_output_ext))
                               || ((N == STAT_ONE_PIN) && mdir_q[0])
                               || ((N == STAT_TWO_PIN) && mdir_q[1]);
            if (p == 0 && b >= KBI_UPPER_LO) begin : g_kbi
                assign pulldn_v[N] = is_kbi_up && cfg_q.kbi_en[b-KBI_UPPER_LO]
                                     && cfg_q.kbi_rise[b-KBI_UPPER_LO];
            end else begin : g_nokbi
                assign pulldn_v[N] = 1'b0;
            end
            assign outonly_v[N] = is_dbg && cfg_q.dbg_gpio;
            // direction bit picks latch or pin even under a peripheral; E7/E6 still read the line
            assign read_v[N] = (blocked_v[N] && N >= OSC_OUT_PIN) ? 1'b0
                             : (dir_v[N] || outonly_v[N]) ? data_v[N] : pin_lvl[N];
            pad_logic u_pad (
                .dir(dir_v[N]),
                .data(data_v[N]),
                .pull_en(pull_v[N]),
                .owned(owned_v[N]),
                .p_oe(PERIPH_OE[N]),
                .p_out(PERIPH_OUT[N]),
                .pull_down(pulldn_v[N]),
                .blocked(blocked_v[N]),
                .out_only(outonly_v[N]),
                .pad(pad_d[N])
            );
        end
    end

    // ---------------- write channel ----------------
    wire aw_fire = S_AXI_AWVALID && awready_q;
    wire w_fire = S_AXI_WVALID && wready_q;
    wire wr_go = aw_have_q && w_have_q && !bvalid_q;
    wire aw_have_d = wr_go ? 1'b0 : (aw_have_q || aw_fire);
    wire w_have_d = wr_go ? 1'b0 : (w_have_q || w_fire);
    wire bvalid_d = wr_go || (bvalid_q && !S_AXI_BREADY);

    // write decode
    wire [3:0] wport = awaddr_q[7:4];
    wire [1:0] wsel = awaddr_q[3:2];
    wire w_port_hit = (wport < 4'(NUM_PORTS)) && (wsel != 2'h3);
    wire w_cfg = (awaddr_q == CFG_ADDR);
    wire w_mdata = (awaddr_q == MODEM_DATA_ADDR);
    wire w_mdir = (awaddr_q == MODEM_DIR_ADDR);
    wire w_stat = (awaddr_q == STATUS_ADDR);
    wire w_hit = w_port_hit || w_cfg || w_mdata || w_mdir || w_stat;
    wire w_en = wr_go && wstrb0_q;

    // address and data may arrive in either order; each is held until used
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb0_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (CE) begin
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            awready_q <= !aw_have_d;
            wready_q <= !w_have_d;
            if (aw_fire) awaddr_q <= S_AXI_AWADDR;
            if (w_fire) wdata_q <= S_AXI_WDATA[13:0];
            if (w_fire) wstrb0_q <= S_AXI_WSTRB[0];
            bvalid_q <= bvalid_d;
            if (wr_go) bresp_q <= w_hit ? RESP_OKAY : RESP_SLVERR;
        end
    end

    // register file; all directions and pulls clear at reset
    for (p = 0; p < NUM_PORTS; p++) begin : g_regs
        always_ff @(posedge CLK or negedge RESET_N) begin
            if (!RESET_N) begin
                data_q[p] <= PORT_RST;
                dir_q[p] <= PORT_RST;
                pull_q[p] <= PORT_RST;
            end else if (CE && w_en && w_port_hit && wport == 4'(p)) begin
                if (wsel == SEL_DATA) data_q[p] <= wdata_q[7:0];
                if (wsel == SEL_DIR) dir_q[p] <= wdata_q[7:0];
                if (wsel == SEL_PULL) pull_q[p] <= wdata_q[7:0];
            end
        end
    end

    // configuration and modem line registers; modem lines start as inputs
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            cfg_q <= CFG_RST;
            mdata_q <= MODEM_RST;
            mdir_q <= MODEM_RST;
        end else if (CE && w_en) begin
            if (w_cfg) cfg_q <= cfg_t'(wdata_q);
            if (w_mdata) mdata_q <= wdata_q[6:0];
            if (w_mdir) mdir_q <= wdata_q[6:0];
        end
    end

    // ---------------- read channel ----------------
    wire ar_fire = S_AXI_ARVALID && arready_q;
    wire rvalid_d = ar_fire || (rvalid_q && !S_AXI_RREADY);
    wire [3:0] rport = S_AXI_ARADDR[7:4];
    wire [1:0] rsel = S_AXI_ARADDR[3:2];
    wire r_port_hit = (rport < 4'(NUM_PORTS)) && (rsel != 2'h3);
    wire [2:0] rp = rport[2:0];
    wire [7:0] r_port_val = (rsel == SEL_DATA) ? read_v[rp*PORT_W +: PORT_W]
                          : (rsel == SEL_DIR) ? dir_q[rp] : pull_q[rp];
    wire [31:0] status_val = {28'h0000000, line_two, line_one, pin_s[DBG_PIN], bkgd_q};
    wire r_cfg = (S_AXI_ARADDR == CFG_ADDR);
    wire r_stat = (S_AXI_ARADDR == STATUS_ADDR);
    wire r_mdata = (S_AXI_ARADDR == MODEM_DATA_ADDR);
    wire r_mdir = (S_AXI_ARADDR == MODEM_DIR_ADDR);
    wire r_hit = r_port_hit || r_cfg || r_stat || r_mdata || r_mdir;
    // modem data read follows the same latch-or-pin choice as the ports
    wire [6:0] mread = (mdir_q & mdata_q) | (~mdir_q & modem_s);
    wire [31:0] r_val = r_port_hit ? {24'h000000, r_port_val}
                      : r_cfg ? {18'h00000, cfg_q}
                      : r_stat ? status_val
                      : r_mdata ? {25'h0000000, mread}
                      : r_mdir ? {25'h0000000, mdir_q} : 32'h00000000;

    // one read in flight; address ready drops until the data is taken
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= RESP_OKAY;
        end else if (CE) begin
            arready_q <= !rvalid_d;
            rvalid_q <= rvalid_d;
            if (ar_fire) rdata_q <= r_val;
            if (ar_fire) rresp_q <= r_hit ? RESP_OKAY : RESP_SLVERR;
        end
    end

    // ---------------- mode strap ----------------
    // level sampled only after the filter has filled following release
    wire strap_done = (strap_cnt_q == STRAP_SETTLE_CYCLES);
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            strap_cnt_q <= 3'h0;
            bkgd_q <= 1'b0;
        end else if (CE && !strap_done) begin
            strap_cnt_q <= strap_cnt_q + 3'h1;
            if (strap_cnt_q == STRAP_SETTLE_CYCLES - 3'h1) begin
                bkgd_q <= !pin_s[DBG_PIN];
            end
        end
    end

    // ---------------- debug bit timer ----------------
    // debug clock equals bus clock here, the fastest case allowed
    wire dbg_fall = dbg_prev_q && !pin_s[DBG_PIN] && !cfg_q.dbg_gpio && strap_done;
    wire bit_last = bit_busy_q && (bit_cnt_q == BIT_CYCLES - 5'h01);
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            dbg_prev_q <= 1'b1;
            bit_busy_q <= 1'b0;
            bit_cnt_q <= 5'h00;
            bit_start_q <= 1'b0;
            bit_end_q <= 1'b0;
        end else if (CE) begin
            dbg_prev_q <= pin_s[DBG_PIN];
            bit_start_q <= dbg_fall && !bit_busy_q;
            bit_end_q <= bit_last;
            if (dbg_fall && !bit_busy_q) begin
                bit_busy_q <= 1'b1;
                bit_cnt_q <= 5'h00;
            end else if (bit_last) begin
                bit_busy_q <= 1'b0;
            end else if (bit_busy_q) begin
                bit_cnt_q <= bit_cnt_q + 5'h01;
            end
        end
    end

    // ---------------- registered pad and side outputs ----------------
    // external interrupt pull flips to pull-down for rising edges
    wire irq_pull = cfg_q.irq_en && cfg_q.irq_pull_en;
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            PAD <= {NUM_PINS{PAD_RST}};
            PERIPH_IN <= '0;
            MODEM_PAD_OUT <= MODEM_RST;
            MODEM_PAD_OE <= MODEM_RST;
            IRQ_PULL_UP <= 1'b0;
            IRQ_PULL_DN <= 1'b0;
        end else if (CE) begin
            PAD <= pad_d;
            PERIPH_IN <= pin_lvl;
            MODEM_PAD_OUT <= mdata_q;
            MODEM_PAD_OE <= mdir_q;
            IRQ_PULL_UP <= irq_pull && !cfg_q.irq_rising;
            IRQ_PULL_DN <= irq_pull && cfg_q.irq_rising;
        end
    end

    assign S_AXI_AWREADY = awready_q;
    assign S_AXI_WREADY = wready_q;
    assign S_AXI_BVALID = bvalid_q;
    assign S_AXI_BRESP = bresp_q;
    assign S_AXI_ARREADY = arready_q;
    assign S_AXI_RVALID = rvalid_q;
    assign S_AXI_RDATA = rdata_q;
    assign S_AXI_RRESP = rresp_q;
    assign ACTIVE_BKGD_MODE = bkgd_q;
    assign BDC_BIT_START = bit_start_q;
    assign BDC_BIT_END = bit_end_q;
endmodule // port_pin_ctrl

// ### testbench/board_model.sv
`timescale 1ns/1ps
module board_model (
    input wire logic clk,
    input wire port_pkg::pad_t [port_pkg::NUM_PINS-1:0] pad,
    input wire logic [port_pkg::NUM_PINS-1:0] ext_en,
    input wire logic [port_pkg::NUM_PINS-1:0] ext_val,
    input wire logic host_low,
    input wire logic [port_pkg::NUM_MODEM-1:0] m_out,
    input wire logic [port_pkg::NUM_MODEM-1:0] m_oe,
    output logic [port_pkg::NUM_PINS-1:0] pin,
    output logic [port_pkg::NUM_MODEM-1:0] m_pin
);
    import port_pkg::*;
    logic tgl_q = 1'b0;
    // floating lines wander each cycle, so a read of one never matches by luck
    always_ff @(posedge clk) tgl_q <= ~tgl_q;
    // pad driver wins, then the board, then the pulls
    always_comb begin
        for (int i = 0; i < NUM_PINS; i++) begin
            pin[i] = pad[i].oe ? pad[i].out : ext_en[i] ? ext_val[i] :
                pad[i].pull_up | (~pad[i].pull_dn & (tgl_q ^ i[0]));
        end
        // host pulls low open-drain; otherwise the pad drives it when enabled, else the pin's pull-up holds it high
        pin[DBG_PIN] = host_low ? 1'b0 : (pad[DBG_PIN].oe ? pad[DBG_PIN].out : 1'b1);
        m_pin = (m_oe & m_out) | (~m_oe & {NUM_MODEM{tgl_q}}); // no pull on modem lines
    end
endmodule // board_model

// ### testbench/port_pin_ctrl_asserts.sv
`timescale 1ns/1ps
module port_pin_ctrl_asserts (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic S_AXI_RVALID,
    input wire port_pkg::pad_t [port_pkg::NUM_PINS-1:0] PAD,
    input wire logic [port_pkg::NUM_MODEM-1:0] MODEM_PAD_OE,
    input wire logic IRQ_PULL_UP,
    input wire logic IRQ_PULL_DN,
    input wire logic ACTIVE_BKGD_MODE,
    input wire logic BDC_BIT_START,
    input wire logic BDC_BIT_END
);
    import port_pkg::*;
    logic out_pull, both_pull, idle_pads;
    logic [3:0] up_cnt_q;
    // debug pin left out of the drive and idle checks: its pull belongs to the debug role
    always_comb begin
        out_pull = 1'b0;
        both_pull = 1'b0;
        idle_pads = 1'b1;
        for (int i = 0; i < NUM_PINS; i++) begin
            both_pull |= PAD[i].pull_up & PAD[i].pull_dn;
            if (i != DBG_PIN) begin
                out_pull |= PAD[i].oe & (PAD[i].pull_up | PAD[i].pull_dn);
                idle_pads &= (PAD[i] == PAD_RST);
            end
        end
    end
    // saturates so it never wraps back into the strap window
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) up_cnt_q <= 4'h0;
        else if (up_cnt_q != 4'hF) up_cnt_q <= up_cnt_q + 4'h1;
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    sequence bit_gap_s; (!BDC_BIT_END)[*8] ##1 (!BDC_BIT_END)[*7]; endsequence
    sequence bit_end_s; BDC_BIT_END ##1 !BDC_BIT_END; endsequence
    chk_reset_idle: assert property ($rose(RESET_N) |-> idle_pads ##1 idle_pads)
        else $error("pads not idle after reset");
    chk_modem_idle: assert property ($rose(RESET_N) |-> MODEM_PAD_OE == '0 ##1 MODEM_PAD_OE == '0)
        else $error("modem line driven after reset");
    chk_out_pull_off: assert property (!out_pull)
        else $error("pull on a driven pad");
    chk_pull_exclusive: assert property (!both_pull)
        else $error("pad pulled both ways");
    chk_irq_exclusive: assert property (!(IRQ_PULL_UP && IRQ_PULL_DN))
        else $error("interrupt pad pulled both ways");
    chk_bit_length: assert property (BDC_BIT_START |=> bit_gap_s ##1 bit_end_s)
        else $error("debug bit length wrong");
    chk_mode_stable: assert property (up_cnt_q > 4'h8 |-> $stable(ACTIVE_BKGD_MODE))
        else $error("mode changed after strap");
    chk_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
        else $error("read answer late");
endmodule // port_pin_ctrl_asserts
bind port_pin_ctrl port_pin_ctrl_asserts port_pin_ctrl_asserts_i (
    .CLK(CLK), .RESET_N(RESET_N), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
    .S_AXI_RVALID(S_AXI_RVALID), .PAD(PAD), .MODEM_PAD_OE(MODEM_PAD_OE),
    .IRQ_PULL_UP(IRQ_PULL_UP), .IRQ_PULL_DN(IRQ_PULL_DN), .ACTIVE_BKGD_MODE(ACTIVE_BKGD_MODE),
    .BDC_BIT_START(BDC_BIT_START), .BDC_BIT_END(BDC_BIT_END)
);

// ### testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import port_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, host_low = 1'b1;
    logic aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0;
    logic [7:0] aw_a = 8'h00, ar_a = 8'h00;
    logic [31:0] w_d = 32'h0, rdat, r_d;
    logic [1:0] rsp, b_resp, r_resp;
    logic [NUM_PINS-1:0] own = '0, poe = '0, pout = '0, ext_v = '0, pin_in, p_in;
    logic [NUM_PINS-1:0] ext_en = '1; // unused pins never float
    logic [NUM_MODEM-1:0] m_pin, m_out, m_oe;
    logic aw_rdy, w_rdy, b_v, ar_rdy, r_v, irq_up, irq_dn, bkgd, bs, be;
    pad_t [NUM_PINS-1:0] pad;
    int fail_count = 0, n_compared = 0;
    port_pin_ctrl port_pin_ctrl_i (
        .CLK(clk), .RESET_N(rst_n), .CE(1'b1), .S_AXI_AWADDR(aw_a), .S_AXI_AWVALID(aw_v),
        .S_AXI_AWREADY(aw_rdy), .S_AXI_WDATA(w_d), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(w_v),
        .S_AXI_WREADY(w_rdy), .S_AXI_BRESP(b_resp), .S_AXI_BVALID(b_v), .S_AXI_BREADY(b_r),
        .S_AXI_ARADDR(ar_a), .S_AXI_ARVALID(ar_v), .S_AXI_ARREADY(ar_rdy), .S_AXI_RDATA(r_d),
        .S_AXI_RRESP(r_resp), .S_AXI_RVALID(r_v), .S_AXI_RREADY(r_r), .PIN_IN(pin_in), .PAD(pad),
        .PERIPH_OWN(own), .PERIPH_OE(poe), .PERIPH_OUT(pout), .PERIPH_IN(p_in),
        .MODEM_PIN_IN(m_pin), .MODEM_PAD_OUT(m_out), .MODEM_PAD_OE(m_oe), .IRQ_PULL_UP(irq_up),
        .IRQ_PULL_DN(irq_dn), .ACTIVE_BKGD_MODE(bkgd), .BDC_BIT_START(bs), .BDC_BIT_END(be)
    );
    board_model board_model_i (.clk(clk), .pad(pad), .ext_en(ext_en), .ext_val(ext_v),
        .host_low(host_low), .m_out(m_out), .m_oe(m_oe), .pin(pin_in), .m_pin(m_pin));
    initial forever #4 clk = ~clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        if (fail_count == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // write: address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        rsp = 2'bxx;
        @(posedge clk);
        {aw_a, w_d, aw_v, w_v, b_r} <= {a, d, 3'h7};
        forever begin
            @(posedge clk);
            if (aw_v && aw_rdy) aw_v <= 1'b0;
            if (w_v && w_rdy) w_v <= 1'b0;
            if (b_v) begin
                rsp = b_resp;
                break;
            end
        end
        b_r <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        rsp = 2'bxx;
        @(posedge clk);
        {ar_a, ar_v, r_r} <= {a, 2'h3};
        forever begin
            @(posedge clk);
            if (ar_v && ar_rdy) ar_v <= 1'b0;
            if (r_v) begin
                {rdat, rsp} = {r_d, r_resp};
                break;
            end
        end
        r_r <= 1'b0;
    endtask
    // hang guard, well past the expected run length
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        tally_and_finish();
    end
    initial begin
        logic [7:0] dir, dat, pl, o, ow, lvl, m;
        int p, t;
        void'($urandom(26449));
        repeat (2) @(posedge clk);
        rst_n <= 1'b1; // host holds the debug pin low across release
        repeat (8) @(posedge clk);
        chk(bkgd, 1);
        host_low <= 1'b0;
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (8) @(posedge clk);
        chk(bkgd, 0);
        for (p = 0; p < NUM_PORTS; p++) begin
            rd(8'(p * 16 + 4));
            chk(rdat, 0);
            rd(8'(p * 16 + 8));
            chk(rdat, 0);
        end
        // a low pulse from the host opens one debug bit
        host_low <= 1'b1;
        repeat (4) @(posedge clk);
        host_low <= 1'b0;
        for (t = 0; t < 20 && !bs; t++) @(posedge clk);
        for (t = 0; t < 30 && !be; t++) @(posedge clk);
        chk(t, 16);
        // random direction, data, pulls and peripheral takeover on ports A to F
        for (int k = 0; k < 16; k++) begin
            p = $urandom_range(5, 0);
            {dir, dat, pl} = 24'($urandom());
            own <= 56'({$urandom(), $urandom()}) & 56'h00_003F_FF0F_FFFF;
            poe <= 56'({$urandom(), $urandom()}) & 56'h00_003F_FF0F_FFFF;
            pout <= 56'({$urandom(), $urandom()});
            ext_v <= 56'({$urandom(), $urandom()});
            wr(8'(p * 16), 32'(dat));
            wr(8'(p * 16 + 4), 32'(dir));
            wr(8'(p * 16 + 8), 32'(pl));
            repeat (8) @(posedge clk);
            ow = own[p * 8 +: 8] & poe[p * 8 +: 8];
            o = ow | (~own[p * 8 +: 8] & dir);
            lvl = (ow & pout[p * 8 +: 8]) | (~ow & ext_v[p * 8 +: 8]);
            m = (p == 4) ? 8'h3F : 8'hFF; // E7 and E6 belong to the modem lines
            rd(8'(p * 16));
            chk(rdat[7:0] & m, ((dir & dat) | (~dir & lvl)) & m);
            for (int b = 0; b < 8; b++) begin
                chk({pad[p * 8 + b].oe, pad[p * 8 + b].pull_up},
                    {o[b], pl[b] & ~o[b] & (own[p * 8 + b] | ~dir[b])});
            end
        end
        own <= '0;
        wr(8'h04, 32'h0);
        wr(8'h08, 32'hF0);
        // rising sense turns the keypad and interrupt pulls into pull-downs
        for (t = 0; t < 2; t++) begin
            wr(CFG_ADDR, t ? 32'h03E8 : 32'h3FF8);
            repeat (3) @(posedge clk);
            for (int b = 4; b < 8; b++) chk({pad[b].pull_up, pad[b].pull_dn}, t ? 2 : 1);
            chk({irq_up, irq_dn}, t ? 2 : 1);
        end
        wr(8'h44, 32'h0);
        wr(MODEM_DIR_ADDR, 32'h03);
        for (t = 0; t < 2; t++) begin
            wr(MODEM_DATA_ADDR, t ? 32'h02 : 32'h01);
            repeat (8) @(posedge clk);
            rd(8'h40);
            chk(rdat[7:6], t ? 1 : 2);
            chk(p_in[STAT_ONE_PIN -: 2], t ? 1 : 2);
            chk({m_oe, m_out}, {7'h03, 7'(t + 1)});
        end
        wr(8'h60, 32'h06);
        wr(8'h64, 32'h06);
        // crystal claims both oscillator pins, the modem clock only the input pin
        for (t = 0; t < 2; t++) begin
            wr(CFG_ADDR, t ? 32'h02 : 32'h01);
            repeat (3) @(posedge clk);
            rd(8'h60);
            chk(rdat[2:1], t ? 1 : 0);
            chk(pad[EXT_CLK_PIN], 4'h8); // latch on out, never driven
            chk(pad[OSC_OUT_PIN].oe, t);
        end
        // debug pin as a port bit drives and reads back its latch despite the host
        wr(CFG_ADDR, 32'h04);
        wr(8'h60, 32'h01);
        host_low <= 1'b1;
        repeat (8) @(posedge clk);
        rd(8'h60);
        chk({pad[DBG_PIN].out, pad[DBG_PIN].oe, rdat[0]}, 7);
        host_low <= 1'b0;
        wr(8'hF0, 32'h5A);
        chk(rsp, RESP_SLVERR);
        rd(8'hF0);
        chk(rdat, 0);
        chk(rsp, RESP_SLVERR);
        tally_and_finish();
    end
endmodule // tb_top
